// ===== src/sector_cmd_pkg.sv
// Purpose: Shared constants and types for the sector verify/write block.
// Assumes: Task-file registers sit at their printed I/O offsets.
// Notes: Geometry values are plain defaults, not taken from any drive.
// Contract
// - Opcodes 40h and 41h run sector verify, no sector data to host.
// - Verify done: busy flag clears and host interrupt rises.
// - Verify success leaves last verified sector address in task file.
// - Verify error stops at failing sector, its address in task file.
// - Verify error sets sector count to sectors left unverified.
// - Opcodes 30h and 31h write count sectors from task-file address.
// - One write covers up to 256 sectors; count zero means 256.
// - Write starts at the sector number register, then following sectors.
// - Head off target track: implied seek, write only after arrival.
// - Each sector is written with buffered data plus CRC and ECC.
// - Write success leaves last written sector address in task file.
// - Write error stops at failing sector, its address in task file.
package sector_cmd_pkg;

	// Task-file offsets on the register port
	localparam logic [9:0] OFS_ERR_FEAT = 10'h1f1;
	localparam logic [9:0] OFS_COUNT    = 10'h1f2;
	localparam logic [9:0] OFS_SECTOR   = 10'h1f3;
	localparam logic [9:0] OFS_CYL_LO   = 10'h1f4;
	localparam logic [9:0] OFS_CYL_HI   = 10'h1f5;
	localparam logic [9:0] OFS_DRV_HEAD = 10'h1f6;
	localparam logic [9:0] OFS_CMD_STAT = 10'h1f7;

	// Opcodes with the variant bit cleared
	localparam logic [7:0] OP_VERIFY = 8'h40;
	localparam logic [7:0] OP_WRITE  = 8'h30;
	localparam logic [7:0] OP_MASK   = 8'hfe;

	// Status byte bit positions
	localparam int ST_BUSY  = 7;
	localparam int ST_READY = 6;
	localparam int ST_SEEKD = 4;
	localparam int ST_DRQ   = 3;
	localparam int ST_ERR   = 0;

	// Drive/head register fields
	localparam int DH_LBA = 6;
	localparam int DH_DEV = 4;

	// Error code for a refused command
	localparam logic [7:0] ERR_ABORT = 8'h04;

	// Values after reset
	localparam logic [7:0] RST_COUNT  = 8'h01;
	localparam logic [7:0] RST_SECTOR = 8'h01;
	localparam logic [7:0] RST_ZERO   = 8'h00;

	// Geometry used for the CHS address step, plus the drive select value
	localparam logic [7:0] SECT_PER_TRACK = 8'h3f;
	localparam logic [3:0] LAST_HEAD      = 4'hf;
	localparam logic [0:0] DRIVE_SEL      = 1'h0;

	// Count zero asks for the largest transfer
	localparam logic [8:0] MAX_SECTORS = 9'h100;

	typedef enum logic [2:0]
	{
		ST_IDLE = 3'h0,
		ST_WBUF = 3'h1,
		ST_CHK  = 3'h3,
		ST_MED  = 3'h2,
		ST_SEEK = 3'h7
	} state_e;

	typedef struct packed
	{
		logic [15:0] cyl;
		logic [3:0]  head;
		logic [7:0]  sector;
	} addr_s;

	typedef struct packed
	{
		logic  valid;
		logic  write;
		logic  genEcc;
		logic  lbaMode;
		addr_s addr;
	} media_req_s;

endpackage : sector_cmd_pkg

// ===== src/sector_addr_step.sv
// Purpose: Next sector address after the current one.
// Assumes: CHS sectors run 1 to the sectors-per-track value.
// Notes: LBA mode counts the 28-bit address straight up.
module sector_addr_step
(
	input  wire logic                   lbaMode,
	input  wire sector_cmd_pkg::addr_s  cur,
	output      sector_cmd_pkg::addr_s  nxt
);

	logic [27:0] lbaNext;

	// LBA is head, cylinder and sector taken as one number
	assign lbaNext = {cur.head, cur.cyl, cur.sector} + 28'h0000001;

	// Step sector, wrap into head, then cylinder
	always_comb
	begin
		nxt = cur;
		if (lbaMode)
		begin
			// Carry runs sector, cylinder low, cylinder high, then head
			nxt.sector = lbaNext[7:0];
			nxt.cyl    = lbaNext[23:8];
			nxt.head   = lbaNext[27:24];
		end
		else if (cur.sector != sector_cmd_pkg::SECT_PER_TRACK)
		begin
			nxt.sector = cur.sector + 8'h01;
		end
		else
		begin
			nxt.sector = 8'h01;
			if (cur.head != sector_cmd_pkg::LAST_HEAD)
			begin
				nxt.head = cur.head + 4'h1;
			end
			else
			begin
				nxt.head = 4'h0;
				nxt.cyl  = cur.cyl + 16'h0001;
			end
		end
	end

endmodule : sector_addr_step

// ===== src/sector_verify_write_cmd.sv
// Purpose: Task-file registers and sequencer for verify and write commands.
// Assumes: Media, servo and sector buffer handshakes are synchronous.
// Notes: Register writes are ignored while the busy flag is set.
//        An interrupt raised as a status read lands stays set.
module sector_verify_write_cmd
(
	input  wire logic                        clk,
	input  wire logic                        rstn,
	input  wire logic [9:0]                  addr,
	input  wire logic [7:0]                  wrData,
	input  wire logic                        wrStb,
	input  wire logic                        rdStb,
	output      logic [7:0]                  rdData,
	output      logic                        intrq,
	output      logic                        drq,
	input  wire logic                        bufReady,
	input  wire logic                        onTrack,
	output      logic                        seekReq,
	input  wire logic                        seekDone,
	output      sector_cmd_pkg::media_req_s  mediaReq,
	input  wire logic                        mediaDone,
	input  wire logic                        mediaErr,
	input  wire logic [7:0]                  mediaErrCode
);

	typedef struct packed
	{
		sector_cmd_pkg::state_e     st;
		logic [7:0]                 errInfo;
		logic [7:0]                 features;
		logic [7:0]                 count;
		logic [7:0]                 sector;
		logic [7:0]                 cylLo;
		logic [7:0]                 cylHi;
		logic [7:0]                 drvHead;
		logic                       busy;
		logic                       drqF;
		logic                       errF;
		logic                       irq;
		logic                       isWrite;
		logic [8:0]                 left;
		logic                       seek;
		sector_cmd_pkg::media_req_s med;
		logic [7:0]                 rd;
	} core_s;

	core_s                 q_r;
	core_s                 q_nxt;
	logic                  rstSync1_r;
	logic                  rstSync2_r;
	sector_cmd_pkg::addr_s curAddr;
	sector_cmd_pkg::addr_s stepAddr;
	logic [7:0]            statusByte;
	logic [7:0]            opBase;
	logic                  devMatch;
	logic                  isVerifyCmd;
	logic                  isWriteCmd;
	logic                  lastSector;
	logic [7:0]            readMux;

	// Opcode with variant bit dropped
	function automatic logic [7:0] op_base(input logic [7:0] code);
		op_base = code & sector_cmd_pkg::OP_MASK;
	endfunction : op_base

	// Sectors asked for; a count of zero asks for the largest transfer
	function automatic logic [8:0] sectors_asked(input logic [7:0] cnt);
		if (cnt == 8'h00)
		begin
			sectors_asked = sector_cmd_pkg::MAX_SECTORS;
		end
		else
		begin
			sectors_asked = {1'b0, cnt};
		end
	endfunction : sectors_asked

	// Reset release through two flops
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rstSync1_r <= 1'b0;
			rstSync2_r <= 1'b0;
		end
		else
		begin
			rstSync1_r <= 1'b1;
			rstSync2_r <= rstSync1_r;
		end
	end

	// Current task-file address
	assign curAddr.cyl    = {q_r.cylHi, q_r.cylLo};
	assign curAddr.head   = q_r.drvHead[3:0];
	assign curAddr.sector = q_r.sector;

	sector_addr_step u_step
	(
		.lbaMode (q_r.drvHead[sector_cmd_pkg::DH_LBA]),
		.cur     (curAddr),
		.nxt     (stepAddr)
	);

	// Status byte as seen on a status read
	always_comb
	begin
		statusByte = 8'h00;
		statusByte[sector_cmd_pkg::ST_BUSY]  = q_r.busy;
		statusByte[sector_cmd_pkg::ST_READY] = 1'b1;
		statusByte[sector_cmd_pkg::ST_SEEKD] = 1'b1;
		statusByte[sector_cmd_pkg::ST_DRQ]   = q_r.drqF;
		statusByte[sector_cmd_pkg::ST_ERR]   = q_r.errF;
	end

	assign opBase   = op_base(wrData);
	assign devMatch = (q_r.drvHead[sector_cmd_pkg::DH_DEV]
		== sector_cmd_pkg::DRIVE_SEL);

	// Opcode decode; the variant bit does not change the command
	assign isVerifyCmd = (opBase == sector_cmd_pkg::OP_VERIFY);
	assign isWriteCmd  = (opBase == sector_cmd_pkg::OP_WRITE);

	// The sector in flight is the last one asked for
	assign lastSector  = (q_r.left == 9'h001);

	// Register read mux; offsets outside the task file read as zero
	always_comb
	begin
		readMux = 8'h00;
		case (addr)
			sector_cmd_pkg::OFS_ERR_FEAT: readMux = q_r.errInfo;
			sector_cmd_pkg::OFS_COUNT:    readMux = q_r.count;
			sector_cmd_pkg::OFS_SECTOR:   readMux = q_r.sector;
			sector_cmd_pkg::OFS_CYL_LO:   readMux = q_r.cylLo;
			sector_cmd_pkg::OFS_CYL_HI:   readMux = q_r.cylHi;
			sector_cmd_pkg::OFS_DRV_HEAD: readMux = q_r.drvHead;
			sector_cmd_pkg::OFS_CMD_STAT: readMux = statusByte;
			default:                      readMux = 8'h00;
		endcase
	end

	// Next state of registers and sequencer
	always_comb
	begin
		q_nxt           = q_r;
		q_nxt.med.valid = 1'b0;
		q_nxt.seek      = 1'b0;
		q_nxt.rd        = 8'h00;

		// Register reads; status read drops the interrupt
		if (rdStb)
		begin
			q_nxt.rd = readMux;
			if (addr == sector_cmd_pkg::OFS_CMD_STAT)
			begin
				q_nxt.irq = 1'b0;
			end
		end

		// Register writes, only while idle
		if (wrStb && !q_r.busy)
		begin
			case (addr)
				sector_cmd_pkg::OFS_ERR_FEAT: q_nxt.features = wrData;
				sector_cmd_pkg::OFS_COUNT:    q_nxt.count    = wrData;
				sector_cmd_pkg::OFS_SECTOR:   q_nxt.sector   = wrData;
				sector_cmd_pkg::OFS_CYL_LO:   q_nxt.cylLo    = wrData;
				sector_cmd_pkg::OFS_CYL_HI:   q_nxt.cylHi    = wrData;
				sector_cmd_pkg::OFS_DRV_HEAD: q_nxt.drvHead  = wrData;
				sector_cmd_pkg::OFS_CMD_STAT:
				begin
					if (devMatch)
					begin
						q_nxt.irq     = 1'b0;
						q_nxt.errF    = 1'b0;
						q_nxt.errInfo = 8'h00;
						q_nxt.left    = sectors_asked(q_r.count);
						if (isVerifyCmd)
						begin
							// Either variant, no data phase
							q_nxt.busy    = 1'b1;
							q_nxt.isWrite = 1'b0;
							q_nxt.st      = sector_cmd_pkg::ST_CHK;
						end
						else if (isWriteCmd)
						begin
							// First sector is the task-file address
							q_nxt.busy    = 1'b1;
							q_nxt.isWrite = 1'b1;
							q_nxt.drqF    = 1'b1;
							q_nxt.st      = sector_cmd_pkg::ST_WBUF;
						end
						else
						begin
							// Unknown opcode is aborted at once
							q_nxt.errF    = 1'b1;
							q_nxt.errInfo = sector_cmd_pkg::ERR_ABORT;
							q_nxt.irq     = 1'b1;
						end
					end
				end
				default: q_nxt.count = q_r.count;
			endcase
		end

		// Sector sequencer
		case (q_r.st)
			sector_cmd_pkg::ST_IDLE:
			begin
				// No data request unless a write starts this cycle
				q_nxt.drqF = q_nxt.drqF
					&& (q_nxt.st == sector_cmd_pkg::ST_WBUF);
			end

			sector_cmd_pkg::ST_WBUF:
			begin
				// Wait until the host has filled the buffer
				if (bufReady)
				begin
					q_nxt.drqF = 1'b0;
					q_nxt.st   = sector_cmd_pkg::ST_CHK;
				end
			end

			sector_cmd_pkg::ST_CHK:
			begin
				if (onTrack)
				begin
					// Start the sector; writes carry CRC and ECC
					q_nxt.med.valid   = 1'b1;
					q_nxt.med.write   = q_r.isWrite;
					q_nxt.med.genEcc  = q_r.isWrite;
					q_nxt.med.lbaMode =
						q_r.drvHead[sector_cmd_pkg::DH_LBA];
					q_nxt.med.addr    = curAddr;
					q_nxt.st          = sector_cmd_pkg::ST_MED;
				end
				else
				begin
					// Implied seek before touching the sector
					q_nxt.seek = 1'b1;
					q_nxt.st   = sector_cmd_pkg::ST_SEEK;
				end
			end

			sector_cmd_pkg::ST_SEEK:
			begin
				// Recheck the track only after arrival
				if (seekDone)
				begin
					q_nxt.st = sector_cmd_pkg::ST_CHK;
				end
			end

			sector_cmd_pkg::ST_MED:
			begin
				if (mediaDone)
				begin
					if (mediaErr)
					begin
						// Stop here; address stays on the failing sector
						q_nxt.errF    = 1'b1;
						q_nxt.errInfo = mediaErrCode;
						q_nxt.count   = q_r.left[7:0];
						q_nxt.busy    = 1'b0;
						q_nxt.irq     = 1'b1;
						q_nxt.st      = sector_cmd_pkg::ST_IDLE;
					end
					else if (lastSector)
					begin
						// Last sector done; address left on it
						q_nxt.count = 8'h00;
						q_nxt.left  = 9'h000;
						q_nxt.busy  = 1'b0;
						q_nxt.irq   = 1'b1;
						q_nxt.st    = sector_cmd_pkg::ST_IDLE;
					end
					else
					begin
						// Advance to the following sector
						q_nxt.left    = q_r.left - 9'h001;
						q_nxt.sector  = stepAddr.sector;
						q_nxt.cylLo   = stepAddr.cyl[7:0];
						q_nxt.cylHi   = stepAddr.cyl[15:8];
						q_nxt.drvHead = {q_r.drvHead[7:4],
							stepAddr.head};
						if (q_r.isWrite)
						begin
							q_nxt.drqF = 1'b1;
							q_nxt.st   = sector_cmd_pkg::ST_WBUF;
						end
						else
						begin
							q_nxt.st = sector_cmd_pkg::ST_CHK;
						end
					end
				end
			end

			default:
			begin
				q_nxt.st = sector_cmd_pkg::ST_IDLE;
			end
		endcase
	end

	// All state but the reset synchroniser flops, cleared under the synchronised reset
	always_ff @(posedge clk or negedge rstSync2_r)
	begin
		if (!rstSync2_r)
		begin
			// Task-file registers
			q_r.errInfo  <= sector_cmd_pkg::RST_ZERO;
			q_r.features <= sector_cmd_pkg::RST_ZERO;
			q_r.count    <= sector_cmd_pkg::RST_COUNT;
			q_r.sector   <= sector_cmd_pkg::RST_SECTOR;
			q_r.cylLo    <= sector_cmd_pkg::RST_ZERO;
			q_r.cylHi    <= sector_cmd_pkg::RST_ZERO;
			q_r.drvHead  <= sector_cmd_pkg::RST_ZERO;
			// Sequencer, flags and handshake outputs
			q_r.st       <= sector_cmd_pkg::ST_IDLE;
			q_r.busy     <= 1'b0;
			q_r.drqF     <= 1'b0;
			q_r.errF     <= 1'b0;
			q_r.irq      <= 1'b0;
			q_r.isWrite  <= 1'b0;
			q_r.left     <= 9'h000;
			q_r.seek     <= 1'b0;
			q_r.med      <= '0;
			q_r.rd       <= sector_cmd_pkg::RST_ZERO;
		end
		else
		begin
			q_r <= q_nxt;
		end
	end

	// Outputs straight from the state flops
	assign rdData   = q_r.rd;
	assign intrq    = q_r.irq;
	assign drq      = q_r.drqF;
	assign seekReq  = q_r.seek;
	assign mediaReq = q_r.med;

endmodule : sector_verify_write_cmd

// ===== test/sector_verify_write_cmd_monitor.sv
// Purpose: Port checker for the verify/write sequencer.
// Assumes: Commands are written only while the block is idle.
// Notes: Bound into the design from the bench top file.
module sector_verify_write_cmd_monitor
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic [9:0] addr,
	input wire logic [7:0] wrData,
	input wire logic wrStb,
	input wire logic rdStb,
	input wire logic [7:0] rdData,
	input wire logic intrq,
	input wire logic drq,
	input wire logic bufReady,
	input wire logic onTrack,
	input wire logic seekReq,
	input wire sector_cmd_pkg::media_req_s mediaReq,
	input wire logic mediaDone,
	input wire logic mediaErr
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rstn);
	// Command writes, a failed sector and a quiet sequencer
	sequence cmdV;
		wrStb && addr == 10'h1f7 && wrData[7:1] == 7'h20;
	endsequence
	sequence cmdW;
		wrStb && addr == 10'h1f7 && wrData[7:1] == 7'h18;
	endsequence
	sequence errEnd;
		mediaDone && mediaErr;
	endsequence
	sequence quiet;
		!mediaReq.valid && !drq && !seekReq;
	endsequence
	// Request, pulse and interrupt relations
	verify_start_a: assert property (
		cmdV ##1 onTrack |=> mediaReq.valid && !mediaReq.write)
		else $error("verify did not reach the media");
	verify_nodata_a: assert property (cmdV |=> (!drq)[*3])
		else $error("verify asked for host data");
	write_drq_a: assert property (cmdW |-> ##[1:2] drq)
		else $error("write did not ask for data");
	drq_hold_a: assert property (drq && !bufReady |=> drq)
		else $error("data request dropped early");
	seek_first_a: assert property (
		mediaReq.valid |-> $past(onTrack))
		else $error("sector access while off track");
	seek_pulse_a: assert property (
		seekReq |=> !seekReq && !mediaReq.valid)
		else $error("seek request not a lone pulse");
	ecc_gen_a: assert property (
		mediaReq.valid && mediaReq.write |-> mediaReq.genEcc)
		else $error("write without code generation");
	err_stop_a: assert property (
		errEnd |=> intrq ##0 quiet[*4])
		else $error("work went on after a failed sector");
	intr_clear_a: assert property (
		rdStb && addr == 10'h1f7 && !mediaDone |=> !intrq)
		else $error("status read left interrupt set");
	rd_idle_a: assert property (!rdStb |=> rdData == 8'h00)
		else $error("read data outside its cycle");
endmodule : sector_verify_write_cmd_monitor

// ===== test/media_partner.sv
// Purpose: Servo, buffer and media stand-in for the sequencer.
// Assumes: Seek and sector requests are answered after lat cycles, lat above 0.
// Notes: Qualified outputs wander while no answer is due.
module media_partner
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic drq,
	input wire logic seekReq,
	input wire sector_cmd_pkg::media_req_s mediaReq,
	input wire logic [3:0] lat,
	input wire logic [7:0] errSec,
	input wire logic errEn,
	input wire logic dropTrk,
	output logic bufReady,
	output logic onTrack,
	output logic seekDone,
	output logic mediaDone,
	output logic mediaErr,
	output logic [7:0] mediaErrCode
);
	logic [3:0] mCnt;
	logic [3:0] sCnt;
	logic hit;
	// Failing sector picked by its address byte
	assign hit = errEn && mediaReq.addr.sector == errSec;
	// Answers to data, seek and sector requests
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
		begin
			{bufReady, seekDone, mediaDone, mediaErr} <= 4'h0;
			onTrack <= 1'b1;
			mediaErrCode <= 8'h00;
			mCnt <= 4'h0;
			sCnt <= 4'h0;
		end
		else
		begin
			bufReady <= drq;
			if (dropTrk)
				onTrack <= 1'b0;
			else if (seekDone)
				onTrack <= 1'b1;
			sCnt <= seekReq ? lat : sCnt - 4'(sCnt != 4'h0);
			seekDone <= sCnt == 4'h1;
			mCnt <= mediaReq.valid ? lat : mCnt - 4'(mCnt != 4'h0);
			mediaDone <= mCnt == 4'h1;
			mediaErr <= mCnt == 4'h1 ? hit : ~mediaErr;
			mediaErrCode <= mCnt == 4'h1 ? 8'h5a : ~mediaErrCode;
		end
endmodule : media_partner

// ===== test/sector_verify_write_cmd_bench.sv
// Purpose: Random and corner runs of verify and write commands.
// Assumes: Partner answers media, seek and buffer requests.
// Notes: Expected task-file values come from a local address step.
module sector_verify_write_cmd_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [9:0] addr = 10'h000;
	logic [7:0] wrData = 8'h00;
	logic wrStb = 1'b0;
	logic rdStb = 1'b0;
	logic [3:0] lat = 4'h1;
	logic [7:0] errSec = 8'h00;
	logic errEn = 1'b0;
	logic dropTrk = 1'b0;
	logic [7:0] rdData;
	logic [7:0] mediaErrCode;
	logic intrq, drq, bufReady, onTrack, seekReq, seekDone;
	logic mediaDone, mediaErr;
	sector_cmd_pkg::media_req_s mediaReq;
	int error_cnt = 0;
	int samples_checked = 0;
	int cyc = 0;
	// Clock of 25 ns period
	always #12.5 clk = ~clk;
	sector_verify_write_cmd i_dut (.clk(clk), .rstn(rstn), .addr(addr),
		.wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData),
		.intrq(intrq), .drq(drq), .bufReady(bufReady), .onTrack(onTrack),
		.seekReq(seekReq), .seekDone(seekDone), .mediaReq(mediaReq),
		.mediaDone(mediaDone), .mediaErr(mediaErr),
		.mediaErrCode(mediaErrCode));
	media_partner i_media (.clk(clk), .rstn(rstn), .drq(drq),
		.seekReq(seekReq), .mediaReq(mediaReq), .lat(lat),
		.errSec(errSec), .errEn(errEn), .dropTrk(dropTrk),
		.bufReady(bufReady), .onTrack(onTrack), .seekDone(seekDone),
		.mediaDone(mediaDone), .mediaErr(mediaErr),
		.mediaErrCode(mediaErrCode));
	task automatic conclude;
		$display("checked %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : conclude
	task automatic chk(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("FAIL %s exp %h got %h", what, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wrData <= d;
		wrStb <= 1'b1;
		@(posedge clk);
		wrStb <= 1'b0;
	endtask : wr
	task automatic rd(input logic [9:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rdStb <= 1'b1;
		@(posedge clk);
		rdStb <= 1'b0;
		#1 d = rdData;
	endtask : rd
	// Address of the sector after a, as {cylinder, head, sector}
	function automatic logic [27:0] step(input logic [27:0] a,
		input logic lba);
		logic [27:0] l;
		l = {a[11:8], a[27:12], a[7:0]} + 28'h1;
		if (lba)
			return {l[23:8], l[27:24], l[7:0]};
		if (a[7:0] < sector_cmd_pkg::SECT_PER_TRACK)
			return a + 28'h1;
		if (a[11:8] != sector_cmd_pkg::LAST_HEAD)
			return {a[27:12], a[11:8] + 4'h1, 8'h01};
		return {a[27:12] + 16'h1, 4'h0, 8'h01};
	endfunction : step
	// One command of n sectors, failing at sector k when k is not 0
	task automatic run(input logic [7:0] op, input int n, input int k,
		input logic lba);
		logic [27:0] a;
		logic [27:0] e;
		logic [7:0] d;
		logic good;
		good = op[7:1] == 7'h20 || op[7:1] == 7'h18;
		a = {16'($urandom), 4'($urandom), 8'($urandom_range(63, 1))};
		e = a;
		for (int j = 1; j < (!good ? 1 : k > 0 ? k : n); j++)
			e = step(e, lba);
		errSec <= e[7:0];
		errEn <= k > 0;
		lat <= 4'($urandom_range(8, 1));
		wr(sector_cmd_pkg::OFS_COUNT, n[7:0]);
		wr(sector_cmd_pkg::OFS_SECTOR, a[7:0]);
		wr(sector_cmd_pkg::OFS_CYL_LO, a[19:12]);
		wr(sector_cmd_pkg::OFS_CYL_HI, a[27:20]);
		wr(sector_cmd_pkg::OFS_DRV_HEAD, {1'b0, lba, 2'b00, a[11:8]});
		dropTrk <= 1'($urandom);
		wr(sector_cmd_pkg::OFS_CMD_STAT, op);
		dropTrk <= 1'b0;
		while (intrq !== 1'b1)
			@(posedge clk);
		rd(sector_cmd_pkg::OFS_CMD_STAT, d);
		chk("status", {7'h28, (!good || k > 0)}, d);
		rd(sector_cmd_pkg::OFS_COUNT, d);
		chk("count", !good ? n[7:0] : k == 0 ? 8'h00 : 8'(n - k + 1),
			d);
		rd(sector_cmd_pkg::OFS_SECTOR, d);
		chk("sector", e[7:0], d);
		rd(sector_cmd_pkg::OFS_CYL_LO, d);
		chk("cyl low", e[19:12], d);
		rd(sector_cmd_pkg::OFS_CYL_HI, d);
		chk("cyl high", e[27:20], d);
		rd(sector_cmd_pkg::OFS_DRV_HEAD, d);
		chk("drive head", {1'b0, lba, 2'b00, e[11:8]}, d);
		if (k > 0 || !good)
		begin
			rd(sector_cmd_pkg::OFS_ERR_FEAT, d);
			chk("error", good ? 8'h5a : sector_cmd_pkg::ERR_ABORT, d);
		end
		$display("test %h n %0d k %0d done", op, n, k);
	endtask : run
	// Cycle ceiling well above the longest run
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			error_cnt++;
			conclude();
		end
	end
	// Reset, register checks, corner commands, then random ones
	initial
	begin
		logic [7:0] d;
		int n;
		void'($urandom(58427));
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		repeat (4) @(posedge clk);
		rd(sector_cmd_pkg::OFS_CMD_STAT, d);
		chk("status at reset", 8'h50, d);
		rd(sector_cmd_pkg::OFS_COUNT, d);
		chk("count at reset", 8'h01, d);
		rd(10'h1f0, d);
		chk("unmapped", 8'h00, d);
		run(8'h40, 3, 0, 1'b0);
		run(8'h41, 4, 2, 1'b0);
		run(8'h30, 2, 0, 1'b1);
		run(8'h31, 4, 3, 1'b0);
		run(8'h31, 256, 0, 1'b0);
		run(8'h40, 256, 256, 1'b1);
		run(8'h20, 2, 0, 1'b0);
		repeat (8)
		begin
			n = $urandom_range(4, 1);
			run({$urandom_range(1, 0) ? 7'h20 : 7'h18, 1'($urandom)}, n,
				$urandom_range(n, 0), 1'($urandom));
		end
		conclude();
	end
endmodule : sector_verify_write_cmd_bench
bind sector_verify_write_cmd sector_verify_write_cmd_monitor i_mon (
	.clk(clk), .rstn(rstn), .addr(addr), .wrData(wrData), .wrStb(wrStb),
	.rdStb(rdStb), .rdData(rdData), .intrq(intrq), .drq(drq),
	.bufReady(bufReady), .onTrack(onTrack), .seekReq(seekReq),
	.mediaReq(mediaReq), .mediaDone(mediaDone), .mediaErr(mediaErr));
